/* psp_port.v */
// Slave parallel port: port D data latch, port E strobes, control and interrupt
//
// Function
// - Enable bit turns on slave mode unless multi-output PWM
// - External master reads/writes data latch asynchronously
// - Strobe pins zero, one, two: read, write, select
// - Write spans select and write both low
// - Write end sets irq flag and input full
// - Read start drives latch, clears output full
// - Latch write during read shows, output full stays
// - Read end releases bus, sets irq flag
// - Analog select forces strobe pin reads to zero
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "psp_defs.vh"
module psp_port (
    // Clock and reset
    input  wire       clk,
    input  wire       rst_n,
    // Register port
    input  wire [3:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    // Parallel data pins
    input  wire [7:0] data_pins_in,
    output wire [7:0] data_pins_out,
    output wire [7:0] data_pins_oe,
    // Strobe pins, bit 0 read, bit 1 write, bit 2 select, all active low
    input  wire [2:0] strobe_pins_in,
    output wire [2:0] strobe_pins_out,
    output wire [2:0] strobe_pins_oe,
    // Interrupt
    output wire       irq
);
    localparam ST_IDLE  = 3'b001;
    localparam ST_WRITE = 3'b010;
    localparam ST_READ  = 3'b100;

    reg  [7:0] latch_reg;
    reg  [7:0] dir_reg;
    reg  [2:0] estrobe_lat_reg;
    reg  [2:0] edir_reg;
    reg        en_reg;
    reg        ibf_reg;
    reg        obf_reg;
    reg        input_overflow_reg;
    reg  [7:0] analog_select_low_reg;
    reg  [1:0] pwm_mode_reg;
    reg  [3:0] stat_reg;
    reg  [3:0] mask_reg;
    reg  [2:0] state_reg;
    reg  [2:0] state_next;
    reg  [7:0] rdata_next;

    wire [7:0] data_sync;
    wire [2:0] strobe_sync;
    wire [2:0] strobe_masked;

    psp_sync #(.W(11)) u_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in ({strobe_pins_in, data_pins_in}),
        .sync_out ({strobe_sync, data_sync})
    );

    assign strobe_masked = strobe_sync & ~{analog_select_low_reg[`PSP_ANS_CS],
                                           analog_select_low_reg[`PSP_ANS_WR],
                                           analog_select_low_reg[`PSP_ANS_RD]};

    wire psp_on = en_reg && (pwm_mode_reg == 2'b00 || pwm_mode_reg == 2'b01);

    wire rd_low = psp_on && !strobe_masked[0];
    wire wr_low = psp_on && !strobe_masked[1];
    wire cs_low = psp_on && !strobe_masked[2];

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (cs_low && wr_low)
                    state_next = ST_WRITE;
                else if (cs_low && rd_low)
                    state_next = ST_READ;
            end
            ST_WRITE: begin
                if (!cs_low || !wr_low)
                    state_next = ST_IDLE;
            end
            ST_READ: begin
                if (!cs_low || !rd_low)
                    state_next = ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
    end

    wire write_end = (state_reg == ST_WRITE) && (state_next == ST_IDLE);
    wire read_start = (state_reg == ST_IDLE) && (state_next == ST_READ);
    wire read_end = (state_reg == ST_READ) && (state_next == ST_IDLE);

    wire sw_wr_latch = reg_wr && (reg_addr == `PSP_ADDR_DATA_PINS ||
                                  reg_addr == `PSP_ADDR_DATA_LATCH);
    wire sw_rd_latch = reg_rd && (reg_addr == `PSP_ADDR_DATA_PINS ||
                                  reg_addr == `PSP_ADDR_DATA_LATCH);
    wire sw_rd_stat = reg_rd && (reg_addr == `PSP_ADDR_IRQ_STATUS);
    wire [3:0] ev = {write_end && ibf_reg, read_end, write_end, write_end || read_end};

    // bus drive during a read; new latch shows at once
    assign data_pins_out = latch_reg;
    assign data_pins_oe = (state_reg == ST_READ) ? 8'hff :
                          (psp_on ? 8'h00 : ~dir_reg);
    assign strobe_pins_out = estrobe_lat_reg;
    assign strobe_pins_oe = psp_on ? 3'b000 : ~edir_reg;
    assign irq = |(stat_reg & mask_reg);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg       <= ST_IDLE;
            latch_reg       <= `PSP_RST_ZERO;
            dir_reg         <= `PSP_RST_DIR;
            estrobe_lat_reg <= 3'h0;
            edir_reg        <= 3'h7;
            en_reg          <= 1'b0;
            ibf_reg         <= 1'b0;
            obf_reg         <= 1'b0;
            input_overflow_reg        <= 1'b0;
            analog_select_low_reg       <= `PSP_RST_ANALOG_SELECT_LOW;
            pwm_mode_reg    <= 2'h0;
            stat_reg        <= 4'h0;
            mask_reg        <= 4'h0;
            reg_rdata       <= `PSP_RST_ZERO;
        end else begin
            state_reg <= state_next;
            reg_rdata <= rdata_next;
            if (write_end)
                latch_reg <= data_sync;
            else if (sw_wr_latch)
                latch_reg <= reg_wdata;
            if (write_end)
                ibf_reg <= 1'b1;
            else if (sw_rd_latch)
                ibf_reg <= 1'b0;
            // output full clear; stays clear in read
            if (read_start)
                obf_reg <= 1'b0;
            else if (sw_wr_latch && state_reg != ST_READ)
                obf_reg <= 1'b1;
            if (write_end && ibf_reg)
                input_overflow_reg <= 1'b1;
            else if (reg_wr && reg_addr == `PSP_ADDR_CTRL_DIR && !reg_wdata[`PSP_CTRL_INPUT_OVERFLOW])
                input_overflow_reg <= 1'b0;
            if (reg_wr) begin
                case (reg_addr)
                    `PSP_ADDR_DATA_DIR:    dir_reg <= reg_wdata;
                    `PSP_ADDR_STROBE_PINS,
                    `PSP_ADDR_STROBE_LAT:  estrobe_lat_reg <= reg_wdata[2:0];
                    `PSP_ADDR_CTRL_DIR: begin
                        en_reg   <= reg_wdata[`PSP_CTRL_EN];
                        edir_reg <= reg_wdata[2:0];
                    end
                    `PSP_ADDR_ANALOG_SELECT_LOW:       analog_select_low_reg <= reg_wdata;
                    `PSP_ADDR_IRQ_MASK:    mask_reg <= reg_wdata[3:0];
                    `PSP_ADDR_PWM_MODE:    pwm_mode_reg <= reg_wdata[1:0];
                    default: ;
                endcase
            end
            // access end sets irq flag; events win over read clear
            stat_reg <= (sw_rd_stat ? 4'h0 : stat_reg) | ev;
        end
    end

    always @* begin
        rdata_next = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `PSP_ADDR_DATA_PINS: rdata_next = psp_on ? latch_reg : data_sync;
                `PSP_ADDR_DATA_LATCH: rdata_next = latch_reg;
                `PSP_ADDR_DATA_DIR: rdata_next = dir_reg;
                `PSP_ADDR_STROBE_PINS: rdata_next = {5'h0, strobe_masked};
                `PSP_ADDR_STROBE_LAT: rdata_next = {5'h0, estrobe_lat_reg};
                `PSP_ADDR_CTRL_DIR: rdata_next = {ibf_reg, obf_reg, input_overflow_reg, en_reg,
                                                  1'b0, edir_reg};
                `PSP_ADDR_ANALOG_SELECT_LOW: rdata_next = analog_select_low_reg;
                `PSP_ADDR_IRQ_STATUS: rdata_next = {4'h0, stat_reg};
                `PSP_ADDR_IRQ_MASK: rdata_next = {4'h0, mask_reg};
                `PSP_ADDR_PWM_MODE: rdata_next = {6'h0, pwm_mode_reg};
                default: rdata_next = 8'h00;
            endcase
        end
    end
endmodule // psp_port

/* psp_defs.vh */
// Register offsets, field positions and reset values of the slave parallel port
`ifndef PSP_DEFS_VH
`define PSP_DEFS_VH
`define PSP_ADDR_DATA_PINS   4'h0
`define PSP_ADDR_DATA_LATCH  4'h1
`define PSP_ADDR_DATA_DIR    4'h2
`define PSP_ADDR_STROBE_PINS 4'h3
`define PSP_ADDR_STROBE_LAT  4'h4
`define PSP_ADDR_CTRL_DIR    4'h5
`define PSP_ADDR_ANALOG_SELECT_LOW       4'h6
`define PSP_ADDR_IRQ_STATUS  4'h7
`define PSP_ADDR_IRQ_MASK    4'h8
`define PSP_ADDR_PWM_MODE    4'h9
`define PSP_CTRL_IBF         7
`define PSP_CTRL_OBF         6
`define PSP_CTRL_INPUT_OVERFLOW        5
`define PSP_CTRL_EN          4
`define PSP_ANS_RD           5
`define PSP_ANS_WR           6
`define PSP_ANS_CS           7
`define PSP_IRQ_ACCESS       0
`define PSP_IRQ_WRITE        1
`define PSP_IRQ_READ         2
`define PSP_IRQ_OVF          3
`define PSP_RST_DIR          8'hff
`define PSP_RST_CTRL         8'h07
`define PSP_RST_ANALOG_SELECT_LOW        8'hff
`define PSP_RST_ZERO         8'h00
`endif

/* psp_sync.v */
// Two flip-flop synchroniser for a bus of asynchronous inputs
`timescale 1ns/1ps
module psp_sync #(
    parameter W = 8
) (
    // Clock and reset
    input  wire         clk,
    input  wire         rst_n,
    // Data
    input  wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);
    reg [W-1:0] meta_reg;
    reg [W-1:0] sync_reg;
    // Meta stage is read only by the second stage
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= {W{1'b1}};
            sync_reg <= {W{1'b1}};
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end
    assign sync_out = sync_reg;
endmodule // psp_sync

/* psp_port_properties.sv */
// Checker for the slave parallel port
`timescale 1ns/1ps
module psp_port_properties (
    // Clock, reset, register port
    input wire       clk,
    input wire       rst_n,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    // Pins and interrupt
    input wire [7:0] data_pins_out,
    input wire [7:0] data_pins_oe,
    input wire [2:0] strobe_pins_in,
    input wire [2:0] strobe_pins_oe,
    input wire       irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire rd_on = data_pins_oe == 8'hff;
    property p_latch; reg_wr && reg_addr == 4'h1 |=> data_pins_out == $past(reg_wdata); endproperty
    a_latch: assert property (p_latch) else $error("latch write lost");
    property p_show; reg_wr && reg_addr == 4'h1 && rd_on && strobe_pins_in == 3'b010
        |=> rd_on && data_pins_out == $past(reg_wdata); endproperty
    a_show: assert property (p_show) else $error("latch not shown in read");
    // Two flops before a read may start
    property p_rd_go; $rose(rd_on) && !$past(reg_wr) |-> $past(strobe_pins_in, 2) == 3'b010; endproperty
    a_rd_go: assert property (p_rd_go) else $error("read drive early");
    property p_rd_end; $fell(rd_on) && !$past(reg_wr) |-> $past(strobe_pins_in, 2) != 3'b010; endproperty
    a_rd_end: assert property (p_rd_end) else $error("read release early");
    property p_wr_end; !$stable(data_pins_out) && !$past(reg_wr) |-> $past(strobe_pins_in[1]); endproperty
    a_wr_end: assert property (p_wr_end) else $error("capture before write end");
    property p_stb; !$stable(strobe_pins_oe) |-> $past(reg_wr) && $past(reg_addr) == 4'h5; endproperty
    a_stb: assert property (p_stb) else $error("strobe drive changed");
    property p_irq; $fell(irq) |-> $past(reg_rd) && $past(reg_addr) == 4'h7
        || $past(reg_wr) && $past(reg_addr) == 4'h8; endproperty
    a_irq: assert property (p_irq) else $error("irq dropped");
    property p_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("read data outside slot");
endmodule // psp_port_properties
bind psp_port psp_port_properties i_psp_port_properties (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe),
    .strobe_pins_in(strobe_pins_in), .strobe_pins_oe(strobe_pins_oe), .irq(irq));

/* psp_host_model.sv */
// External processor driving the strobes and data bus
`timescale 1ns/1ps
module psp_host_model (
    // Clock
    input wire       clk,
    // Bus
    input wire [7:0] d_in,
    output reg [7:0] d_out,
    output reg       d_oe,
    output reg [2:0] strobe_n
);
    initial {d_out, d_oe, strobe_n} = 12'h007;
    task wr(input [7:0] d, input integer hold);
        @(posedge clk);
        d_out <= d;
        d_oe <= 1'b1;
        strobe_n <= 3'b001;
        repeat (hold) @(posedge clk);
        strobe_n <= 3'b111;
        repeat (4) @(posedge clk);
        d_oe <= 1'b0;
    endtask
    task rd(output [7:0] d, input integer hold);
        @(posedge clk);
        strobe_n <= 3'b010;
        repeat (hold) @(posedge clk);
        d = d_in;
        strobe_n <= 3'b111;
        repeat (4) @(posedge clk);
    endtask
endmodule // psp_host_model

/* psp_port_test.sv */
// Self-checking bench of the slave parallel port
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks = num_checks + 1; if ((got) !== (ex)) begin \
    n_errors = n_errors + 1; $display("ERROR %0s exp %h got %h", nm, ex, got); end end
module psp_port_test;
    reg        clk = 1'b0;
    reg        rst_n = 1'b0;
    reg  [3:0] reg_addr = 4'h0;
    reg  [7:0] reg_wdata = 8'h00;
    reg        reg_wr = 1'b0;
    reg        reg_rd = 1'b0;
    wire [7:0] reg_rdata, d_out, d_oe, h_d;
    wire [2:0] h_s, s_out, s_oe;
    wire       h_oe, irq;
    reg  [7:0] cyc = 8'h00, d, w, got, lat = 8'h00;
    integer    n_errors = 0, num_checks = 0, seed = 32'hb35c, i, m;
    always #20 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 8'h01;
    // Released bus shows a moving pattern, never a stale byte
    wire [7:0] pins = d_oe & d_out | ~d_oe & (h_oe ? h_d : cyc ^ 8'h5a);
    psp_port i_psp_port (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .data_pins_in(pins), .data_pins_out(d_out), .data_pins_oe(d_oe),
        .strobe_pins_in(h_s), .strobe_pins_out(s_out), .strobe_pins_oe(s_oe), .irq(irq));
    psp_host_model i_psp_host_model (.clk(clk), .d_in(pins), .d_out(h_d), .d_oe(h_oe),
        .strobe_n(h_s));
    function [7:0] ctl(input input_buffer_full, input ovf);
        ctl = {input_buffer_full, 1'b0, ovf, 5'h17};
    endfunction
    task rw(input [3:0] a, input [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rr(input [3:0] a, input [7:0] ex, input [63:0] nm);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        `CHK(nm, ex, reg_rdata)
    endtask
    task end_sim;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rr(4'h5, 8'h07, "ctrl");
        rr(4'h3, 8'h00, "strobes");
        rr(4'hf, 8'h00, "unmapped");
        rw(4'h6, 8'h00);
        rr(4'h3, 8'h07, "strobes");
        rw(4'h8, 8'h0f);
        rw(4'h5, 8'h17);
        rw(4'h4, 8'h05);
        @(negedge clk);
        `CHK("stb_oe", 3'h0, s_oe)
        `CHK("stb_out", 3'h5, s_out)
        // Modes 2 and 3 must keep the port deaf
        for (m = 0; m < 4; m = m + 1) begin
            rw(4'h9, m[7:0]);
            for (i = 0; i < 2; i = i + 1) begin
                d = $random(seed);
                i_psp_host_model.wr(d, 3 + ($random(seed) & 3));
            end
            if (m < 2) lat = d;
            `CHK("irq", m < 2, irq)
            rr(4'h5, ctl(m < 2, m < 2), "ctrl");
            rr(4'h7, m < 2 ? 8'h0b : 8'h00, "status");
            rr(4'h1, lat, "latch");
            rw(4'h5, 8'h17);
        end
        rw(4'h9, 8'h00);
        d = $random(seed);
        rw(4'h1, d);
        rr(4'h5, 8'h57, "obf");
        i_psp_host_model.rd(got, 5);
        `CHK("read", d, got)
        rr(4'h7, 8'h05, "status");
        w = $random(seed);
        fork
            i_psp_host_model.rd(got, 9);
            begin repeat (4) @(posedge clk); rw(4'h1, w); end
        join
        `CHK("late", w, got)
        rr(4'h5, 8'h17, "obf");
        rr(4'h7, 8'h05, "status");
        rw(4'h8, 8'h00);
        i_psp_host_model.wr(8'h3c, 3);
        `CHK("masked", 1'b0, irq)
        rr(4'h7, 8'h03, "status");
        end_sim;
    end
    initial begin
        #200000;
        n_errors = n_errors + 1;
        end_sim;
    end
endmodule // psp_port_test
